//--- cfcr_top.v
`timescale 1ns/10ps
`include "cfcr_defs.vh"
module cfcr_top (
  input wire i_ref_clk,
  input wire i_reset,
  // protocol engine events, same clock
  input wire i_tx_err,
  input wire i_rx_err,
  input wire i_tx_ok,
  input wire i_rx_ok,
  input wire i_bit_tick,
  input wire i_bus_rx,
  // received frame for fifo filtering
  input wire i_frame_valid,
  input wire [28:0] i_frame_id,
  input wire i_frame_ide,
  input wire i_frame_rtr,
  // to protocol engine
  output wire o_active_flag,
  output wire o_tx_allow,
  output wire o_rx_allow,
  output wire [1:0] o_state,
  output wire o_fifo_accept,
  output wire o_irq,
  // axi4-lite slave
  input wire [7:0] i_awaddr,
  input wire i_awvalid,
  output wire o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output wire o_wready,
  output wire [1:0] o_bresp,
  output wire o_bvalid,
  input wire i_bready,
  input wire [7:0] i_araddr,
  input wire i_arvalid,
  output wire o_arready,
  output wire [31:0] o_rdata,
  output wire [1:0] o_rresp,
  output wire o_rvalid,
  input wire i_rready
);

  // ==========================================================
  // declarations
  reg bus_s1_reg, bus_s2_reg, active_flag_reg, tx_allow_reg, rx_allow_reg;
  reg accept_reg, irq_reg, awready_reg, wready_reg, aw_full_reg, w_full_reg;
  reg bvalid_reg, arready_reg, rvalid_reg, rd_ok;
  reg [1:0] state_reg, state_next, ctrl_reg, bresp_reg, rresp_reg;
  reg [3:0] run_reg, int_stat_reg, int_stat_next, int_mask_reg, w_strb_reg;
  reg [7:0] seq_reg, aw_addr_reg;
  reg [28:0] mask_a_reg, mask_b_reg;
  reg [31:0] cmp_a_reg, cmp_b_reg, w_data_reg, rdata_reg, rd_mux;
  wire [8:0] tec, rec;
  wire busoff, err_any, recovered, clr_cnt, match_a, match_b, do_write;
  wire wr_cfg, wr_ok;
  wire [3:0] w1c, events;
  wire [31:0] wmask;
  // ==========================================================
  // outputs
  assign o_active_flag = active_flag_reg;
  assign o_tx_allow = tx_allow_reg;
  assign o_rx_allow = rx_allow_reg;
  assign o_state = state_reg;
  assign o_fifo_accept = accept_reg;
  assign o_irq = irq_reg;
  assign o_awready = awready_reg;
  assign o_wready = wready_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_arready = arready_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;

  // ==========================================================
  // bus pin synchroniser
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      bus_s1_reg <= 1'b1;
      bus_s2_reg <= 1'b1;
    end else begin
      bus_s1_reg <= i_bus_rx;
      bus_s2_reg <= bus_s1_reg;
    end
  end

  // ==========================================================
  // error counters
  assign busoff = (state_reg == `CFCR_ST_BUSOFF);
  assign err_any = ~busoff & (i_tx_err | i_rx_err);
  assign recovered = busoff & i_bit_tick & bus_s2_reg &
                     (run_reg == `CFCR_RECESSIVE_RUN - 4'h1) &
                     (seq_reg == `CFCR_RECOVER_RUNS - 8'h01);
  assign clr_cnt = recovered;

  cfcr_err_cnt u_tec (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_clear(clr_cnt),
    .i_inc(~busoff & i_tx_err),
    .i_dec(~busoff & i_tx_ok),
    .o_count(tec)
  );
  cfcr_err_cnt u_rec (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_clear(clr_cnt),
    .i_inc(~busoff & i_rx_err),
    .i_dec(~busoff & i_rx_ok),
    .o_count(rec)
  );

  // ==========================================================
  // fault confinement state machine
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `CFCR_ST_ACTIVE: begin
        if (tec > `CFCR_BUSOFF_LIMIT) begin
          state_next = `CFCR_ST_BUSOFF;
        end else if ((tec > `CFCR_PASSIVE_LIMIT) |
                     (rec > `CFCR_PASSIVE_LIMIT)) begin
          state_next = `CFCR_ST_PASSIVE;
        end
      end
      `CFCR_ST_PASSIVE: begin
        if (tec > `CFCR_BUSOFF_LIMIT) begin
          state_next = `CFCR_ST_BUSOFF;
        end else if ((tec <= `CFCR_PASSIVE_LIMIT) &
                     (rec <= `CFCR_PASSIVE_LIMIT)) begin
          state_next = `CFCR_ST_ACTIVE;
        end
      end
      `CFCR_ST_BUSOFF: begin
        if (recovered) begin
          state_next = `CFCR_ST_ACTIVE;
        end
      end
      default: state_next = `CFCR_ST_ACTIVE;
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_reg <= `CFCR_ST_ACTIVE;
      active_flag_reg <= 1'b0;
      tx_allow_reg <= 1'b0;
      rx_allow_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      // error flag only while error-active
      active_flag_reg <= err_any &
                         (state_reg == `CFCR_ST_ACTIVE);
      tx_allow_reg <= (state_next != `CFCR_ST_BUSOFF);
      rx_allow_reg <= (state_next != `CFCR_ST_BUSOFF);
    end
  end

  // ==========================================================
  // bus-off recovery: runs of recessive bits
  always @(posedge i_ref_clk) begin
    if (i_reset | ~busoff) begin
      run_reg <= 4'h0;
      seq_reg <= 8'h00;
    end else if (i_bit_tick) begin
      if (~bus_s2_reg) begin
        run_reg <= 4'h0;
      end else if (run_reg == `CFCR_RECESSIVE_RUN - 4'h1) begin
        run_reg <= 4'h0;
        seq_reg <= seq_reg + 8'h01;
      end else begin
        run_reg <= run_reg + 4'h1;
      end
    end
  end

  // ==========================================================
  // receive fifo filter
  cfcr_id_filter u_filt_a (
    .i_compare(cmp_a_reg),
    .i_mask(mask_a_reg),
    .i_id(i_frame_id),
    .i_ide(i_frame_ide),
    .i_rtr(i_frame_rtr),
    .o_match(match_a)
  );
  cfcr_id_filter u_filt_b (
    .i_compare(cmp_b_reg),
    .i_mask(mask_b_reg),
    .i_id(i_frame_id),
    .i_ide(i_frame_ide),
    .i_rtr(i_frame_rtr),
    .o_match(match_b)
  );

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      accept_reg <= 1'b0;
    end else begin
      accept_reg <= i_frame_valid & ~busoff &
                    ctrl_reg[`CFCR_CTRL_FIFO_MODE] &
                    ctrl_reg[`CFCR_CTRL_FIFO_EN] &
                    (match_a | match_b);
    end
  end

  // ==========================================================
  // interrupts
  assign events[`CFCR_INT_ERR] = err_any;
  assign events[`CFCR_INT_PASSIVE] = (state_reg != `CFCR_ST_PASSIVE) &
                                     (state_next == `CFCR_ST_PASSIVE);
  assign events[`CFCR_INT_BUSOFF] = ~busoff &
                                    (state_next == `CFCR_ST_BUSOFF);
  assign events[`CFCR_INT_RECOVER] = recovered;
  assign w1c = (do_write & (aw_addr_reg == `CFCR_INT_STAT_OFS)) ?
               (w_data_reg[3:0] & wmask[3:0]) : 4'h0;

  always @* begin
    int_stat_next = (int_stat_reg & ~w1c) | events; // set wins
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      int_stat_reg <= 4'h0;
      irq_reg <= 1'b0;
    end else begin
      int_stat_reg <= int_stat_next;
      irq_reg <= |(int_stat_next & int_mask_reg);
    end
  end

  // ==========================================================
  // axi write channel
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_lane
      assign wmask[8*b+7:8*b] = {8{w_strb_reg[b]}};
    end
  endgenerate
  assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wr_cfg = (aw_addr_reg == `CFCR_CMP_A_OFS) |
                  (aw_addr_reg == `CFCR_CMP_B_OFS) |
                  (aw_addr_reg == `CFCR_MASK_A_OFS) |
                  (aw_addr_reg == `CFCR_MASK_B_OFS);
  assign wr_ok = (aw_addr_reg == `CFCR_CTRL_OFS) |
                 (aw_addr_reg == `CFCR_INT_STAT_OFS) |
                 (aw_addr_reg == `CFCR_INT_MASK_OFS) |
                 (wr_cfg & ctrl_reg[`CFCR_CTRL_FIFO_MODE]);

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= `CFCR_RESET_ZERO;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `CFCR_RESP_OKAY;
    end else begin
      if (awready_reg & i_awvalid) begin
        awready_reg <= 1'b0;
        aw_full_reg <= 1'b1;
        aw_addr_reg <= {i_awaddr[7:2], 2'h0};
      end else if (~aw_full_reg) begin
        awready_reg <= 1'b1;
      end
      if (wready_reg & i_wvalid) begin
        wready_reg <= 1'b0;
        w_full_reg <= 1'b1;
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
      end else if (~w_full_reg) begin
        wready_reg <= 1'b1;
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? `CFCR_RESP_OKAY : `CFCR_RESP_SLVERR;
      end else if (bvalid_reg & i_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // control and filter registers
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      ctrl_reg <= 2'h0;
      int_mask_reg <= 4'h0;
      cmp_a_reg <= `CFCR_RESET_ZERO;
      cmp_b_reg <= `CFCR_RESET_ZERO;
      mask_a_reg <= 29'h00000000;
      mask_b_reg <= 29'h00000000;
    end else if (do_write & wr_ok) begin
      case (aw_addr_reg)
        `CFCR_CTRL_OFS: begin
          ctrl_reg <= (ctrl_reg & ~wmask[1:0]) |
                      (w_data_reg[1:0] & wmask[1:0]);
        end
        `CFCR_INT_MASK_OFS: begin
          int_mask_reg <= (int_mask_reg & ~wmask[3:0]) |
                          (w_data_reg[3:0] & wmask[3:0]);
        end
        `CFCR_CMP_A_OFS: begin
          cmp_a_reg <= (cmp_a_reg & ~wmask) | (w_data_reg & wmask);
        end
        `CFCR_CMP_B_OFS: begin
          cmp_b_reg <= (cmp_b_reg & ~wmask) | (w_data_reg & wmask);
        end
        `CFCR_MASK_A_OFS: begin
          mask_a_reg <= (mask_a_reg & ~wmask[28:0]) |
                        (w_data_reg[28:0] & wmask[28:0]);
        end
        `CFCR_MASK_B_OFS: begin
          mask_b_reg <= (mask_b_reg & ~wmask[28:0]) |
                        (w_data_reg[28:0] & wmask[28:0]);
        end
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // ==========================================================
  // axi read channel
  always @* begin
    rd_mux = `CFCR_RESET_ZERO;
    rd_ok = 1'b1;
    case ({i_araddr[7:2], 2'h0})
      `CFCR_CTRL_OFS: rd_mux = {30'h00000000, ctrl_reg};
      `CFCR_STATE_OFS: rd_mux = {30'h00000000, state_reg};
      `CFCR_ERRCNT_OFS: rd_mux = {7'h00, rec, 7'h00, tec};
      `CFCR_INT_STAT_OFS: rd_mux = {28'h0000000, int_stat_reg};
      `CFCR_INT_MASK_OFS: rd_mux = {28'h0000000, int_mask_reg};
      `CFCR_CMP_A_OFS: rd_mux = cmp_a_reg;
      `CFCR_CMP_B_OFS: rd_mux = cmp_b_reg;
      `CFCR_MASK_A_OFS: rd_mux = {3'h0, mask_a_reg};
      `CFCR_MASK_B_OFS: rd_mux = {3'h0, mask_b_reg};
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= `CFCR_RESET_ZERO;
      rresp_reg <= `CFCR_RESP_OKAY;
    end else begin
      if (arready_reg & i_arvalid) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= rd_ok ? `CFCR_RESP_OKAY : `CFCR_RESP_SLVERR;
      end else if (rvalid_reg & i_rready) begin
        rvalid_reg <= 1'b0;
      end else if (~rvalid_reg) begin
        arready_reg <= 1'b1;
      end
    end
  end

endmodule // cfcr_top

//--- cfcr_defs.vh
// Contract
// - tx error flag seen bumps transmit counter; receive error bumps receive counter.
// - each good transmitted or received frame lowers the matching counter.
// - transmit and receive stay allowed in error-active and error-passive.
// - error-active node requests an active error flag on every detected error.
// - either counter above 127 moves error-active to error-passive.
// - error-passive node never requests an active error flag.
// - transmit counter above 255 enters bus-off.
// - bus-off blocks traffic until 128 runs of 11 recessive bits or reset.
// - after recovery the node returns to error-active by itself.
// - error, error-passive and bus-off interrupts each enable separately.
// - enabled single-error interrupt fires on every detected error; the code raises none for errors seen in bus-off.
// - receive fifo uses mailboxes 28 to 31; config refused in normal mode.
// - two compare entries, two masks, frame type select, 11 or 29 bit ids.
// - mask bit zero ignores id bit, one requires it to match.
`ifndef CFCR_DEFS_VH
`define CFCR_DEFS_VH
// ==========================================================
// register byte offsets
`define CFCR_CTRL_OFS 8'h00
`define CFCR_STATE_OFS 8'h04
`define CFCR_ERRCNT_OFS 8'h08
`define CFCR_INT_STAT_OFS 8'h0C
`define CFCR_INT_MASK_OFS 8'h10
`define CFCR_CMP_A_OFS 8'h14
`define CFCR_CMP_B_OFS 8'h18
`define CFCR_MASK_A_OFS 8'h1C
`define CFCR_MASK_B_OFS 8'h20
// ==========================================================
// fields
`define CFCR_CTRL_FIFO_MODE 0
`define CFCR_CTRL_FIFO_EN 1
`define CFCR_CMP_RTR 29
`define CFCR_CMP_IDE 31
`define CFCR_INT_ERR 0
`define CFCR_INT_PASSIVE 1
`define CFCR_INT_BUSOFF 2
`define CFCR_INT_RECOVER 3
`define CFCR_ERRCNT_REC_LSB 16
// ==========================================================
// fault confinement states and limits
`define CFCR_ST_ACTIVE 2'h0
`define CFCR_ST_PASSIVE 2'h1
`define CFCR_ST_BUSOFF 2'h2
`define CFCR_PASSIVE_LIMIT 9'h07F
`define CFCR_BUSOFF_LIMIT 9'h0FF
`define CFCR_RECESSIVE_RUN 4'hB
`define CFCR_RECOVER_RUNS 8'h80
`define CFCR_FIFO_FIRST_MBX 5'h1C
`define CFCR_FIFO_LAST_MBX 5'h1F
// ==========================================================
// reset values and bus answers
`define CFCR_RESET_ZERO 32'h00000000
`define CFCR_RESP_OKAY 2'h0
`define CFCR_RESP_SLVERR 2'h2
`endif

//--- cfcr_err_cnt.v
`timescale 1ns/10ps
`include "cfcr_defs.vh"
module cfcr_err_cnt (
  input wire i_ref_clk,
  input wire i_reset,
  input wire i_clear,
  input wire i_inc,
  input wire i_dec,
  output reg [8:0] o_count
);
  // ==========================================================
  // saturating up, floor at zero
  always @(posedge i_ref_clk) begin
    if (i_reset | i_clear) begin
      o_count <= 9'h000;
    end else if (i_inc) begin
      if (o_count != 9'h1FF) begin
        o_count <= o_count + 9'h001;
      end
    end else if (i_dec & (o_count != 9'h000)) begin
      o_count <= o_count - 9'h001;
    end
  end
endmodule // cfcr_err_cnt

//--- cfcr_id_filter.v
`timescale 1ns/10ps
`include "cfcr_defs.vh"
module cfcr_id_filter (
  input wire [31:0] i_compare,
  input wire [28:0] i_mask,
  input wire [28:0] i_id,
  input wire i_ide,
  input wire i_rtr,
  output wire o_match
);
  // ==========================================================
  // id compare under mask, frame type and format
  wire [28:0] diff;
  wire [28:0] used;
  assign used = i_ide ? 29'h1FFFFFFF : 29'h000007FF;
  assign diff = (i_id ^ i_compare[28:0]) & i_mask & used;
  assign o_match = (diff == 29'h00000000) &
                   (i_rtr == i_compare[`CFCR_CMP_RTR]) &
                   (i_ide == i_compare[`CFCR_CMP_IDE]);
endmodule // cfcr_id_filter

//--- cfcr_chk.sv
`timescale 1ns/10ps
`include "cfcr_defs.vh"
// ==========================================================
// fault confinement checker
module cfcr_chk (
  input wire i_ref_clk,
  input wire i_reset,
  input wire i_tx_err,
  input wire i_rx_err,
  input wire i_bit_tick,
  input wire i_frame_valid,
  input wire i_arvalid,
  input wire o_arready,
  input wire o_rvalid,
  input wire o_active_flag,
  input wire o_tx_allow,
  input wire o_rx_allow,
  input wire [1:0] o_state,
  input wire o_fifo_accept
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  sequence s_err_active;
    (i_tx_err || i_rx_err) && o_state == `CFCR_ST_ACTIVE;
  endsequence
  sequence s_busoff_run;
    (o_state == `CFCR_ST_BUSOFF) [*2];
  endsequence
  sequence s_left_busoff;
    o_state == `CFCR_ST_ACTIVE && $past(o_state) == `CFCR_ST_BUSOFF;
  endsequence
  property p_flag_active;
    s_err_active |=> o_active_flag;
  endproperty
  property p_no_flag_passive;
    o_active_flag |-> $past(o_state) == `CFCR_ST_ACTIVE;
  endproperty
  property p_passive_cause;
    o_state == `CFCR_ST_PASSIVE && $past(o_state) == `CFCR_ST_ACTIVE
      |-> $past(i_tx_err || i_rx_err, 2);
  endproperty
  property p_busoff_cause;
    o_state == `CFCR_ST_BUSOFF && $past(o_state) != `CFCR_ST_BUSOFF
      |-> $past(i_tx_err, 2);
  endproperty
  property p_busoff_blocks;
    s_busoff_run |-> !o_tx_allow && !o_rx_allow;
  endproperty
  property p_allow;
    (o_state != `CFCR_ST_BUSOFF) [*3] |-> o_tx_allow && o_rx_allow;
  endproperty
  property p_recover;
    s_left_busoff ##0 !$past(i_reset) |-> $past(i_bit_tick)
      || $past(i_bit_tick, 2) || $past(i_bit_tick, 3);
  endproperty
  property p_accept_cause;
    o_fifo_accept |-> $past(i_frame_valid);
  endproperty
  property p_busoff_reject;
    i_frame_valid && o_state == `CFCR_ST_BUSOFF |=> !o_fifo_accept;
  endproperty
  property p_read_answer;
    i_arvalid && o_arready |=> o_rvalid;
  endproperty
  a_flag_active: assert property (p_flag_active)
    else $error("active flag missing");
  a_no_flag_passive: assert property (p_no_flag_passive)
    else $error("flag outside active state");
  a_passive_cause: assert property (p_passive_cause)
    else $error("passive entered without error");
  a_busoff_cause: assert property (p_busoff_cause)
    else $error("bus-off entered without tx error");
  a_busoff_blocks: assert property (p_busoff_blocks)
    else $error("traffic allowed in bus-off");
  a_allow: assert property (p_allow)
    else $error("traffic blocked outside bus-off");
  a_recover: assert property (p_recover)
    else $error("bus-off left without bit tick");
  a_accept_cause: assert property (p_accept_cause)
    else $error("accept without frame");
  a_busoff_reject: assert property (p_busoff_reject)
    else $error("frame accepted in bus-off");
  a_read_answer: assert property (p_read_answer)
    else $error("read answer late");
endmodule // cfcr_chk
bind cfcr_top cfcr_chk u_chk (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
  .i_tx_err(i_tx_err), .i_rx_err(i_rx_err), .i_bit_tick(i_bit_tick),
  .i_frame_valid(i_frame_valid), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rvalid(o_rvalid),
  .o_active_flag(o_active_flag), .o_tx_allow(o_tx_allow),
  .o_rx_allow(o_rx_allow), .o_state(o_state),
  .o_fifo_accept(o_fifo_accept));

//--- cfcr_peer.sv
`timescale 1ns/10ps
// ==========================================================
// other nodes: bit ticks and bus level, idle recessive
module cfcr_peer (
  input wire i_ref_clk,
  input wire i_reset,
  input wire i_start,
  input wire [10:0] i_bits,
  input wire i_level,
  output reg o_bit_tick = 1'h0,
  output reg o_bus_rx = 1'h1,
  output reg o_busy = 1'h0
);
  reg [10:0] left_reg = 11'h000;
  reg [1:0] phase_reg = 2'h0;
  always @(posedge i_ref_clk) begin
    o_bit_tick <= 1'h0;
    if (i_reset) begin
      o_busy <= 1'h0;
      o_bus_rx <= 1'h1;
    end else if (i_start) begin
      left_reg <= i_bits;
      phase_reg <= 2'h0;
      o_busy <= 1'h1;
      o_bus_rx <= i_level;
    end else if (o_busy) begin
      phase_reg <= phase_reg + 2'h1;
      if (phase_reg == 2'h3) begin
        o_bit_tick <= 1'h1;
        left_reg <= left_reg - 11'h001;
        o_busy <= (left_reg != 11'h001);
      end
    end else begin
      o_bus_rx <= 1'h1;
    end
  end
endmodule // cfcr_peer

//--- cfcr_tb.sv
`timescale 1ns/10ps
`include "cfcr_defs.vh"
// ==========================================================
// fault confinement and fifo filter bench
module can_fault_confinement_fifo_rx_tb_top;
  reg clk = 1'h0, rst = 1'h1, txe = 1'h0, rxe = 1'h0, txo = 1'h0;
  reg rxo = 1'h0, fv = 1'h0, fide = 1'h0, frtr = 1'h0, fvq = 1'h0;
  reg awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
  reg start = 1'h0, lvl = 1'h1;
  reg [28:0] fid = 29'h0;
  reg [7:0] awa = 8'h00, ara = 8'h00;
  reg [10:0] nb = 11'h000;
  reg [31:0] wd = 32'h0, seed = 32'hA3973F5C, m, r;
  reg [33:0] e;
  reg [33:0] rq[$];
  reg [1:0] wq[$];
  reg aq[$];
  wire aw_r, w_r, bv, ar_r, rv, act, txa, rxa, acc, irq, tick, bus, busy;
  wire [1:0] br, rr, st;
  wire [31:0] rd;
  integer n_errors = 0, n_tests = 0, nflag = 0, k, i, j;
  always #10 clk = ~clk;
  cfcr_top u_dut (.i_ref_clk(clk), .i_reset(rst), .i_tx_err(txe),
    .i_rx_err(rxe), .i_tx_ok(txo), .i_rx_ok(rxo), .i_bit_tick(tick),
    .i_bus_rx(bus), .i_frame_valid(fv), .i_frame_id(fid),
    .i_frame_ide(fide), .i_frame_rtr(frtr), .o_active_flag(act),
    .o_tx_allow(txa), .o_rx_allow(rxa), .o_state(st),
    .o_fifo_accept(acc), .o_irq(irq), .i_awaddr(awa), .i_awvalid(awv),
    .o_awready(aw_r), .i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(wv),
    .o_wready(w_r), .o_bresp(br), .o_bvalid(bv), .i_bready(bry),
    .i_araddr(ara), .i_arvalid(arv), .o_arready(ar_r), .o_rdata(rd),
    .o_rresp(rr), .o_rvalid(rv), .i_rready(rry));
  cfcr_peer u_peer (.i_ref_clk(clk), .i_reset(rst), .i_start(start),
    .i_bits(nb), .i_level(lvl), .o_bit_tick(tick), .o_bus_rx(bus),
    .o_busy(busy));
  // ========================================================
  // shared tasks
  task chk(input [8*8:1] nm, input [31:0] s, input [31:0] x);
    begin
      n_tests = n_tests + 1;
      if (s !== x) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, x, s);
      end
    end
  endtask
  task test_done;
    begin
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task tmo;
    begin
      n_errors = n_errors + 1;
      $display("[FAIL] wait expected done seen hang");
      test_done;
    end
  endtask
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  task ax(input w, input [7:0] a, input [31:0] d, input [1:0] x);
    reg f;
    begin
      f = 1'h0;
      if (w) wq.push_back(x);
      else rq.push_back({x, d});
      @(posedge clk);
      if (w) begin
        awa <= a; wd <= d; awv <= 1'h1; wv <= 1'h1; bry <= 1'h1;
      end else begin
        ara <= a; arv <= 1'h1; rry <= 1'h1;
      end
      for (k = 0; k < 40 && !f; k = k + 1) begin
        @(posedge clk);
        if (aw_r) awv <= 1'h0;
        if (w_r) wv <= 1'h0;
        if (ar_r) arv <= 1'h0;
        if (bv && bry) begin bry <= 1'h0; f = 1'h1; end
        if (rv && rry) begin rry <= 1'h0; f = 1'h1; end
      end
      if (!f) tmo;
    end
  endtask
  task ev(input integer w, input integer n);
    for (i = 0; i < n; i = i + 1) begin
      @(posedge clk);
      txe <= (w == 0); rxe <= (w == 1); txo <= (w == 2); rxo <= (w == 3);
      @(posedge clk);
      {txe, rxe, txo, rxo} <= 4'h0;
      repeat (4) @(posedge clk);
    end
  endtask
  task bits(input [10:0] n, input l);
    begin
      @(posedge clk);
      nb <= n; lvl <= l; start <= 1'h1;
      @(posedge clk);
      start <= 1'h0;
      @(posedge clk);
      for (k = 0; k < 8200 && busy; k = k + 1) @(posedge clk);
      if (busy) tmo;
    end
  endtask
  task fr(input [28:0] d, input ide, input rtr, input x);
    begin
      aq.push_back(x);
      @(posedge clk);
      fid <= d; fide <= ide; frtr <= rtr; fv <= 1'h1;
      @(posedge clk);
      fv <= 1'h0;
    end
  endtask
  // ========================================================
  // result monitor
  always @(posedge clk) begin
    fvq <= fv;
    if (act) nflag = nflag + 1;
    if (rv && rry) begin
      e = rq.pop_front();
      chk("rdata", rd, e[31:0]);
      chk("rresp", {30'h0, rr}, {30'h0, e[33:32]});
    end
    if (bv && bry) chk("bresp", {30'h0, br}, {30'h0, wq.pop_front()});
    if (fvq) chk("accept", acc, aq.pop_front());
  end
  // ========================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    for (j = 0; j < 5; j = j + 1) ax(0, 4 * j, 0, `CFCR_RESP_OKAY);
    ax(0, 8'h40, 0, `CFCR_RESP_SLVERR);
    ax(1, 8'h44, 32'h1, `CFCR_RESP_SLVERR);
    ev(1, 1);
    chk("irq", irq, 0);
    ax(0, `CFCR_INT_STAT_OFS, 32'h1, `CFCR_RESP_OKAY);
    ax(1, `CFCR_INT_MASK_OFS, 32'hF, `CFCR_RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq", irq, 1);
    ax(1, `CFCR_INT_STAT_OFS, 32'h1, `CFCR_RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq", irq, 0);
    ev(1, 127);
    chk("flags", nflag, 128);
    chk("state", st, `CFCR_ST_PASSIVE);
    ev(1, 1);
    chk("flags", nflag, 128);
    chk("allow", {txa, rxa}, 2'h3);
    ax(0, `CFCR_ERRCNT_OFS, 32'h00810000, `CFCR_RESP_OKAY);
    ax(0, `CFCR_INT_STAT_OFS, 32'h3, `CFCR_RESP_OKAY);
    ax(1, `CFCR_INT_STAT_OFS, 32'hF, `CFCR_RESP_OKAY);
    ev(3, 2);
    chk("state", st, `CFCR_ST_ACTIVE);
    ev(2, 1);
    ax(0, `CFCR_ERRCNT_OFS, 32'h007F0000, `CFCR_RESP_OKAY);
    ev(0, 256);
    chk("state", st, `CFCR_ST_BUSOFF);
    chk("allow", {txa, rxa}, 2'h0);
    ev(0, 1);
    ev(1, 1);
    ax(0, `CFCR_ERRCNT_OFS, 32'h007F0100, `CFCR_RESP_OKAY);
    ax(0, `CFCR_INT_STAT_OFS, 32'h7, `CFCR_RESP_OKAY);
    ax(1, `CFCR_INT_STAT_OFS, 32'hF, `CFCR_RESP_OKAY);
    ax(1, `CFCR_CTRL_OFS, 32'h3, `CFCR_RESP_OKAY);
    fr(29'h0, 0, 0, 0);
    ax(1, `CFCR_CTRL_OFS, 32'h0, `CFCR_RESP_OKAY);
    bits(3, 1);
    bits(1, 0);
    bits(1407, 1);
    repeat (6) @(posedge clk);
    chk("state", st, `CFCR_ST_BUSOFF);
    bits(1, 1);
    repeat (6) @(posedge clk);
    chk("state", st, `CFCR_ST_ACTIVE);
    ax(0, `CFCR_ERRCNT_OFS, 32'h0, `CFCR_RESP_OKAY);
    ax(0, `CFCR_INT_STAT_OFS, 32'h8, `CFCR_RESP_OKAY);
    ax(1, `CFCR_CMP_A_OFS, 32'h5A, `CFCR_RESP_SLVERR);
    ax(0, `CFCR_CMP_A_OFS, 32'h0, `CFCR_RESP_OKAY);
    ax(1, `CFCR_CTRL_OFS, 32'h1, `CFCR_RESP_OKAY);
    ax(1, `CFCR_CMP_A_OFS, 32'h5A, `CFCR_RESP_OKAY);
    ax(1, `CFCR_MASK_A_OFS, 32'h7F8, `CFCR_RESP_OKAY);
    ax(1, `CFCR_CMP_B_OFS, 32'hA1234567, `CFCR_RESP_OKAY);
    ax(1, `CFCR_MASK_B_OFS, 32'h1FFFFFFF, `CFCR_RESP_OKAY);
    ax(1, `CFCR_CTRL_OFS, 32'h3, `CFCR_RESP_OKAY);
    fr(29'h05F, 0, 0, 1);
    fr(29'h062, 0, 0, 0);
    fr(29'h05A, 0, 1, 0);
    fr(29'h0800005A, 0, 0, 1);
    fr(29'h1234567, 1, 1, 1);
    fr(29'h1234566, 1, 1, 0);
    fr(29'h05A, 1, 0, 0);
    for (j = 0; j < 8; j = j + 1) begin
      seed = xs(seed);
      m = seed;
      seed = xs(seed);
      r = j[0] ? seed : (seed & ~m);
      ax(1, `CFCR_CTRL_OFS, 32'h1, `CFCR_RESP_OKAY);
      ax(1, `CFCR_MASK_B_OFS, {3'h0, m[28:0]}, `CFCR_RESP_OKAY);
      ax(1, `CFCR_CTRL_OFS, 32'h3, `CFCR_RESP_OKAY);
      fr(29'h1234567 ^ r[28:0], 1, 1, (r[28:0] & m[28:0]) == 0);
    end
    ax(1, `CFCR_CTRL_OFS, 32'h1, `CFCR_RESP_OKAY);
    fr(29'h05A, 0, 0, 0);
    repeat (3) @(posedge clk);
    test_done;
  end
endmodule // can_fault_confinement_fifo_rx_tb_top
